// >>> hdl/tsc_defs.svh
// Purpose: Constants of the transmit timeslot channel control block
// Assumes: Included by its bare name
// Notes: Offsets are the low twelve address bits of the channel block
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TSC_SLOT_CTRL_FIRST 12'h300
`define TSC_SLOT_CTRL_LAST 12'h317
`define TSC_SDLSR_ADDR 12'h10a
`define TSC_ID_ADDR 12'h1fe
`define TSC_REV_ADDR 12'h1ff

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TSC_LAPD_SEL_HI 7
`define TSC_LAPD_SEL_LO 6
`define TSC_ZERO_SEL_HI 5
`define TSC_ZERO_SEL_LO 4
`define TSC_DE_SRC_HI 3
`define TSC_DE_SRC_LO 2

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define TSC_SLOT_CTRL_RESET 8'h80
`define TSC_SDLSR_RESET 8'h00
`define TSC_DDS_CODE 8'h98
`define TSC_BIT7_MASK 8'h02
`define TSC_BIT8_MASK 8'h01
`define TSC_SLOT_COUNT 24

`endif

// >>> hdl/tsc_pkg.sv
// Purpose: Types of the transmit timeslot channel control block
// Assumes: Nothing beyond the standard language
// Notes: Enum order matches the two-bit field encodings
package tsc_pkg;

	// Transmitter choice for a D/E timeslot
	typedef enum logic [1:0] {
		LAPD_TX1,
		LAPD_TX2,
		LAPD_FROM_SDL,
		LAPD_TX3
	} tsc_lapd_sel_t;

	// Zero code suppression choice
	typedef enum logic [1:0] {
		ZS_NONE,
		ZS_BIT7,
		ZS_ALT,
		ZS_DDS
	} tsc_zero_sel_t;

	// One timeslot octet with its framing context
	typedef struct packed {
		logic [4:0] slot;
		logic de_slot;
		logic sig_frame;
		logic sig_bit;
		logic [7:0] octet;
	} tsc_slot_word_t;

endpackage

// >>> hdl/tsc_fifo.sv
// Purpose: Flop-based FIFO with valid and ready on both sides
// Assumes: Synchronous active-low reset, clock enable freezes all state
// Notes: Flags are registered from the next count
module tsc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [CW-1:0] count;

	wire do_wr = wr_valid & wr_ready;
	wire do_rd = rd_valid & rd_ready;
	wire [AW-1:0] next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
	wire [AW-1:0] next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
	wire [CW-1:0] next_count = (do_wr && !do_rd) ? count + CW'(1) :
		(!do_wr && do_rd) ? count - CW'(1) : count;

	assign rd_data = mem[rd_ptr];

	always_ff @(posedge clock) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			wr_ready <= 1'b0;
			rd_valid <= 1'b0;
		end else if (ce) begin
			if (do_wr)
				wr_ptr <= next_wr_ptr;
			if (do_rd)
				rd_ptr <= next_rd_ptr;
			count <= next_count;
			wr_ready <= (next_count != CW'(DEPTH));
			rd_valid <= (next_count != '0);
		end
	end

	always_ff @(posedge clock) begin
		if (ce && do_wr)
			mem[wr_ptr] <= wr_data;
	end
endmodule

// >>> hdl/tsc_top.sv
// Purpose: Per-timeslot transmit channel control with identification registers
// Assumes: Inputs synchronous to clock; one octet per accepted input beat
// Notes: Bit 1 is the octet MSB, bit 8 its LSB, as on the line
// Overview of operation
// - Fixed read-only identification byte, writes ignored
// - Read-only revision byte, may change per revision
// - Twenty-four consecutive control registers, slot 0 first
// - Field selects transmitter 1, 2, 3 or the SDLSR-chosen D/E source
// - Every transmitter can feed its chosen D/E slots
// - Only transmitter 1 feeds the framing datalink
// - Code 00 passes, 01 stuffs bit 7
// - Alternate mode: bit 8, or bit 7 on signaling
// - DDS mode replaces zero octet with 0x98
`include "tsc_defs.svh"

module tsc_top
	import tsc_pkg::*;
#(
	parameter int SLOTS = `TSC_SLOT_COUNT,
	parameter int FIFO_DEPTH = 16,
	// Arbitrary neutral value
	parameter logic [7:0] DEVICE_ID = 8'h5c,
	// Arbitrary neutral value
	parameter logic [7:0] REVISION_ID = 8'h07
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic in_valid,
	output logic in_ready,
	input wire tsc_slot_word_t in_word,
	input wire logic [2:0][7:0] lapd_octet,
	input wire logic [3:0][7:0] de_source_octet,
	output logic [2:0] lapd_take,
	output logic de_source_take,
	input wire logic fdl_lapd1_bit,
	output logic fdl_bit,
	output logic out_valid,
	input wire logic out_ready,
	output tsc_slot_word_t out_word
);

	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	logic [7:0] tx_timeslot_control [SLOTS];
	logic [7:0] signaling_datalink_select_register;

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	wire [11:0] slot_offset = reg_addr - `TSC_SLOT_CTRL_FIRST;
	wire hit_slot_ctrl = (reg_addr >= `TSC_SLOT_CTRL_FIRST) && (reg_addr <= `TSC_SLOT_CTRL_LAST);
	wire hit_sdlsr = (reg_addr == `TSC_SDLSR_ADDR);
	wire hit_id = (reg_addr == `TSC_ID_ADDR);
	wire hit_rev = (reg_addr == `TSC_REV_ADDR);
	wire [4:0] reg_slot = slot_offset[4:0];

	wire [7:0] slot_ctrl_read = hit_slot_ctrl ? tx_timeslot_control[reg_slot] : 8'h00;

	wire [7:0] id_read = hit_id ? DEVICE_ID : 8'h00;

	wire [7:0] rev_read = hit_rev ? REVISION_ID : 8'h00;

	wire [7:0] sdlsr_read = hit_sdlsr ? signaling_datalink_select_register : 8'h00;
	wire [7:0] next_rdata = slot_ctrl_read | id_read | rev_read | sdlsr_read;

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// one register per timeslot
	genvar gi;
	generate
		for (gi = 0; gi < SLOTS; gi++) begin : g_slot
			wire slot_wr = reg_write && hit_slot_ctrl && (reg_slot == 5'(gi));
			always_ff @(posedge clock) begin
				if (!resetn)
					tx_timeslot_control[gi] <= `TSC_SLOT_CTRL_RESET;
				else if (ce && slot_wr)
					tx_timeslot_control[gi] <= reg_wdata;
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!resetn)
			signaling_datalink_select_register <= `TSC_SDLSR_RESET;
		else if (ce && reg_write && hit_sdlsr)
			signaling_datalink_select_register <= reg_wdata;
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge clock) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (ce)
			reg_rdata <= reg_read ? next_rdata : 8'h00;
	end

	// ------------------------------------------------------------------------
	// Per-slot control lookup
	// ------------------------------------------------------------------------
	wire slot_in_range = (in_word.slot < 5'(SLOTS));
	wire [7:0] slot_ctrl = slot_in_range ? tx_timeslot_control[in_word.slot] : `TSC_SLOT_CTRL_RESET;
	wire tsc_lapd_sel_t lapd_select = tsc_lapd_sel_t'(slot_ctrl[`TSC_LAPD_SEL_HI:`TSC_LAPD_SEL_LO]);
	wire tsc_zero_sel_t zero_select = tsc_zero_sel_t'(slot_ctrl[`TSC_ZERO_SEL_HI:`TSC_ZERO_SEL_LO]);
	wire [1:0] de_slot_source_select =
		signaling_datalink_select_register[`TSC_DE_SRC_HI:`TSC_DE_SRC_LO];

	// ------------------------------------------------------------------------
	// D/E octet source
	// ------------------------------------------------------------------------
	logic [7:0] de_octet;
	logic [2:0] take_mask;
	logic take_sdl;

	always_comb begin
		de_octet = in_word.octet;
		take_mask = 3'b000;
		take_sdl = 1'b0;
		unique case (lapd_select)
			LAPD_TX1: begin
				de_octet = lapd_octet[0];
				take_mask = 3'b001;
			end
			LAPD_TX2: begin
				de_octet = lapd_octet[1];
				take_mask = 3'b010;
			end
			LAPD_FROM_SDL: begin
				de_octet = de_source_octet[de_slot_source_select];
				take_sdl = 1'b1;
			end
			LAPD_TX3: begin
				de_octet = lapd_octet[2];
				take_mask = 3'b100;
			end
		endcase
	end

	// any transmitter on its D/E slots
	wire [7:0] slot_octet = in_word.de_slot ? de_octet : in_word.octet;

	// ------------------------------------------------------------------------
	// Zero code suppression
	// ------------------------------------------------------------------------
	wire octet_zero = (slot_octet == 8'h00);
	wire upper_zero = (slot_octet[7:1] == 7'h00);
	logic [7:0] coded_octet;

	always_comb begin
		coded_octet = slot_octet;
		unique case (zero_select)
			ZS_NONE:
				coded_octet = slot_octet;
			ZS_BIT7:
				coded_octet = octet_zero ? (slot_octet | `TSC_BIT7_MASK) : slot_octet;
			ZS_ALT: begin
				if (!in_word.sig_frame)
					coded_octet = octet_zero ? (slot_octet | `TSC_BIT8_MASK) : slot_octet;
				else
					coded_octet = (upper_zero && !in_word.sig_bit) ?
						(slot_octet | `TSC_BIT7_MASK) : slot_octet;
			end
			ZS_DDS:
				coded_octet = octet_zero ? `TSC_DDS_CODE : slot_octet;
		endcase
	end

	// ------------------------------------------------------------------------
	// Word into the FIFO
	// ------------------------------------------------------------------------
	tsc_slot_word_t fifo_in_word;
	tsc_slot_word_t fifo_out_word;
	logic fifo_in_ready;
	logic fifo_out_valid;

	always_comb begin
		fifo_in_word = in_word;
		fifo_in_word.octet = coded_octet;
	end

	wire in_accept = in_valid && fifo_in_ready;
	wire out_load = !out_valid || out_ready;
	wire fifo_out_ready = out_load;

	assign in_ready = fifo_in_ready;

	tsc_fifo #(
		.WIDTH($bits(tsc_slot_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.ce(ce),
		.wr_valid(in_valid),
		.wr_ready(fifo_in_ready),
		.wr_data(fifo_in_word),
		.rd_valid(fifo_out_valid),
		.rd_ready(fifo_out_ready),
		.rd_data(fifo_out_word)
	);

	// ------------------------------------------------------------------------
	// Transmitter handshakes
	// ------------------------------------------------------------------------
	// pulse the feeding transmitter
	always_ff @(posedge clock) begin
		if (!resetn) begin
			lapd_take <= 3'b000;
			de_source_take <= 1'b0;
		end else if (ce) begin
			lapd_take <= (in_accept && in_word.de_slot) ? take_mask : 3'b000;
			de_source_take <= in_accept && in_word.de_slot && take_sdl;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			fdl_bit <= 1'b0;
		else if (ce)
			fdl_bit <= fdl_lapd1_bit;
	end

	// ------------------------------------------------------------------------
	// Output register
	// ------------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_word <= '0;
		end else if (ce && out_load) begin
			out_valid <= fifo_out_valid;
			if (fifo_out_valid)
				out_word <= fifo_out_word;
		end
	end

endmodule

// >>> dv/tsc_top_asserts.sv
// Purpose: Port checks of the timeslot control block
// Assumes: Clock enable held high
// Notes: Bound to every tsc_top
module tsc_top_asserts
	import tsc_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = 8'h5c,
	parameter logic [7:0] REVISION_ID = 8'h07
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [11:0] reg_addr,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire tsc_slot_word_t in_word,
	input wire logic [2:0] lapd_take,
	input wire logic de_source_take,
	input wire logic fdl_lapd1_bit,
	input wire logic fdl_bit,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire tsc_slot_word_t out_word
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	AST_ID_BYTE: assert property (reg_read && reg_addr == 12'h1fe |=> reg_rdata == DEVICE_ID)
		else $error("id byte wrong");
	AST_REV_BYTE: assert property (reg_read && reg_addr == 12'h1ff |=> reg_rdata == REVISION_ID)
		else $error("revision byte wrong");
	AST_RDATA_CAUSE: assert property (reg_rdata != 8'h00 |-> $past(reg_read))
		else $error("read data without read");
	AST_TAKE_ONE: assert property (in_valid && in_ready && in_word.de_slot |=> $onehot({lapd_take, de_source_take}))
		else $error("source not consumed once");
	AST_TAKE_NONE: assert property (!(in_valid && in_ready && in_word.de_slot) |=> {lapd_take, de_source_take} == 4'h0)
		else $error("stray source consume");
	AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
		else $error("output dropped while stalled");
	AST_OUT_LATENCY: assert property ($rose(out_valid) |-> $past(in_valid && in_ready, 2))
		else $error("output without accept");
	AST_FDL: assert property (1'b1 |=> fdl_bit == $past(fdl_lapd1_bit))
		else $error("datalink bit lost");
	cover property (!in_ready);
	cover property (de_source_take);
	cover property (out_valid && !out_ready);
endmodule

bind tsc_top tsc_top_asserts #(.DEVICE_ID(DEVICE_ID), .REVISION_ID(REVISION_ID)) u_chk (.clock(clock),
	.resetn(resetn), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .in_valid(in_valid),
	.in_ready(in_ready), .in_word(in_word), .lapd_take(lapd_take), .de_source_take(de_source_take),
	.fdl_lapd1_bit(fdl_lapd1_bit), .fdl_bit(fdl_bit), .out_valid(out_valid), .out_ready(out_ready),
	.out_word(out_word));

// >>> dv/tsc_line_sink.sv
// Purpose: Far end taking the processed octets
// Assumes: Stall driven after a clock edge
// Notes: Counts and keeps the last octet taken
module tsc_line_sink
	import tsc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic stall,
	input wire logic out_valid,
	output logic out_ready,
	input wire tsc_slot_word_t out_word,
	output logic [7:0] last_octet,
	output logic [7:0] n_got
);
	timeunit 1ns;
	timeprecision 1ns;
	assign out_ready = !stall;
	always_ff @(posedge clock) begin
		if (!resetn) begin
			last_octet <= 8'h00;
			n_got <= 8'h00;
		end else if (out_valid && out_ready) begin
			last_octet <= out_word.octet;
			n_got <= n_got + 8'h01;
		end
	end
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench of the timeslot control block
// Assumes: Clock enable tied high
// Notes: Ends through close_out
module tb_top
	import tsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Arbitrary id values
	localparam logic [7:0] ID_VAL = 8'h5c;
	localparam logic [7:0] REV_VAL = 8'h07;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic in_valid = 1'b0;
	logic fdl_lapd1_bit = 1'b0;
	logic stall = 1'b0;
	tsc_slot_word_t in_word = '0;
	logic [2:0][7:0] lapd_octet = {8'h33, 8'h22, 8'h11};
	logic [3:0][7:0] de_source_octet = {8'h47, 8'h46, 8'h45, 8'h44};
	logic [7:0] reg_rdata, last_octet, n_got;
	logic in_ready, de_source_take, fdl_bit, out_valid, out_ready;
	logic [2:0] lapd_take;
	tsc_slot_word_t out_word;
	int n_fail = 0;
	int checks_done = 0;

	tsc_top #(.DEVICE_ID(ID_VAL), .REVISION_ID(REV_VAL)) dut (.clock(clock), .resetn(resetn), .ce(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
		.lapd_octet(lapd_octet), .de_source_octet(de_source_octet), .lapd_take(lapd_take),
		.de_source_take(de_source_take), .fdl_lapd1_bit(fdl_lapd1_bit), .fdl_bit(fdl_bit),
		.out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
	tsc_line_sink u_sink (.clock(clock), .resetn(resetn), .stall(stall), .out_valid(out_valid),
		.out_ready(out_ready), .out_word(out_word), .last_octet(last_octet), .n_got(n_got));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic limit(input int i);
		if (i >= 40) begin
			n_fail++;
			close_out();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		check(reg_rdata, exp);
		@(posedge clock);
	endtask
	task automatic send(input tsc_slot_word_t w, input logic [7:0] exp);
		logic [7:0] base;
		int i;
		base = n_got;
		in_word <= w;
		in_valid <= 1'b1;
		@(posedge clock);
		for (i = 0; i < 40 && !in_ready; i++)
			@(posedge clock);
		limit(i);
		in_valid <= 1'b0;
		for (i = 0; i < 40 && n_got == base; i++)
			@(posedge clock);
		limit(i);
		check(last_octet, exp);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd(12'h300, 8'h80);
		wr(12'h1fe, 8'h00);
		wr(12'h1ff, 8'h00);
		rd(12'h1fe, ID_VAL);
		rd(12'h1ff, REV_VAL);
		wr(12'h317, 8'h4f);
		rd(12'h317, 8'h4f);
		rd(12'h316, 8'h80);
		wr(12'h318, 8'h5a);
		rd(12'h318, 8'h00);
	endtask
	task automatic t_source();
		logic [7:0] exp [4];
		exp = '{lapd_octet[0], lapd_octet[1], de_source_octet[2], lapd_octet[2]};
		wr(12'h10a, 8'h08);
		for (int c = 0; c < 4; c++) begin
			wr(12'h301, {c[1:0], 6'h00});
			send('{5'd1, 1'b1, 1'b0, 1'b0, 8'hff}, exp[c]);
		end
	endtask
	task automatic t_zero();
		logic [7:0] exp [4] = '{8'h00, 8'h02, 8'h01, 8'h98};
		for (int z = 0; z < 4; z++) begin
			wr(12'h302, {2'b00, z[1:0], 4'h0});
			send('{5'd2, 1'b0, 1'b0, 1'b0, 8'h00}, exp[z]);
			send('{5'd2, 1'b0, 1'b0, 1'b0, 8'h10}, 8'h10);
		end
		wr(12'h302, 8'h20);
		send('{5'd2, 1'b0, 1'b1, 1'b0, 8'h01}, 8'h03);
		send('{5'd2, 1'b0, 1'b1, 1'b1, 8'h01}, 8'h01);
	endtask
	task automatic t_fill();
		logic [7:0] base;
		int sent;
		int i;
		base = n_got;
		sent = 0;
		stall <= 1'b1;
		in_word <= '{5'd3, 1'b0, 1'b0, 1'b0, 8'h5a};
		in_valid <= 1'b1;
		for (i = 0; i < 40 && sent == i; i++) begin
			@(posedge clock);
			if (in_ready)
				sent++;
		end
		limit(i);
		in_valid <= 1'b0;
		check({7'h00, sent >= 16}, 8'h01);
		repeat (4) @(posedge clock);
		check(n_got, base);
		stall <= 1'b0;
		for (i = 0; i < 40 && n_got != base + 8'(sent); i++)
			@(posedge clock);
		limit(i);
		check({7'h00, in_ready}, 8'h01);
	endtask
	task automatic t_fdl();
		for (int k = 0; k < 4; k++) begin
			fdl_lapd1_bit <= k[0];
			@(posedge clock);
			@(posedge clock);
			check({7'h00, fdl_bit}, {7'h00, k[0]});
		end
	endtask

	initial begin
		forever #20 clock = ~clock;
	end
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_regs();
		t_source();
		t_zero();
		t_fill();
		t_fdl();
		close_out();
	end
endmodule
